// ---- verilog/sllc_defs.svh ----
// Constants for the serial link control register bank.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef SLLC_DEFS_SVH
`define SLLC_DEFS_SVH

// ----------------------------------------------------------------------------
// Register indices and byte addresses
// ----------------------------------------------------------------------------
`define SLLC_IDX_LINK       8'h04
`define SLLC_IDX_CONV       8'h05
`define SLLC_IDX_STAT       8'h10
`define SLLC_ADDR_LINK      (`SLLC_IDX_LINK << 2)
`define SLLC_ADDR_CONV      (`SLLC_IDX_CONV << 2)
`define SLLC_ADDR_STAT      (`SLLC_IDX_STAT << 2)

// ----------------------------------------------------------------------------
// Reset values of the fixed fields
// ----------------------------------------------------------------------------
`define SLLC_CFG_LINK_RST   1'h0
`define SLLC_TEST_PAT_RST   1'h0
`define SLLC_INTF_TYPE_RST  2'h0
`define SLLC_REV_EN_RST     1'h1
`define SLLC_FWD_EN_RST     1'h1
`define SLLC_METHOD_RST     1'h0
`define SLLC_JIT_DIS_RST    1'h1
`define SLLC_LEVEL_RST      2'h3
`define SLLC_CONV_RSVD      4'h0

// ----------------------------------------------------------------------------
// Interface type codes and timing
// ----------------------------------------------------------------------------
`define SLLC_INTF_I2C       2'h0
`define SLLC_INTF_UART      2'h1
`define SLLC_BLANK_TIME_US  500
`define SLLC_CLK_MHZ        50
`define SLLC_BLANK_CW       15
`define SLLC_DATA_W         32

`endif

// ---- verilog/sllc_pkg.sv ----
// Types shared by the serial link control register bank.
// Assumes sllc_defs.svh on the include path.
`default_nettype none
`include "sllc_defs.svh"

package sllc_pkg;

   // -------------------------------------------------------------------------
   // Register layouts, most significant field first
   // -------------------------------------------------------------------------
   typedef struct packed {
      logic       serial_link_enable;
      logic       config_link_enable;
      logic       test_pattern_enable;
      logic       sleep_mode;
      logic [1:0] local_interface_type;
      logic       reverse_channel_enable;
      logic       forward_channel_enable;
   } sllc_link_t;

   typedef struct packed {
      logic       conversion_method;
      logic       jitter_filter_disable;
      logic [1:0] output_level_select;
      logic [3:0] reserved;
   } sllc_conv_t;

   // -------------------------------------------------------------------------
   // Whole state of the top module
   // -------------------------------------------------------------------------
   typedef struct packed {
      sllc_link_t                link;
      sllc_conv_t                conv;
      logic                      pready;
      logic                      pslverr;
      logic [`SLLC_DATA_W-1:0]   prdata;
      logic                      rc_active;
      logic                      i2c_active;
      logic                      uart_active;
      logic                      lcc_disable;
   } sllc_state_t;

   typedef struct packed {
      logic                      busy;
      logic [`SLLC_BLANK_CW-1:0] count;
   } sllc_timer_t;

endpackage

`default_nettype wire

// ---- verilog/sllc_blank_timer.sv ----
// Holds busy high for CYCLES clocks after each restart pulse.
// Assumes restart_i is a one-cycle pulse synchronous to clk_i.
`default_nettype none
`include "sllc_defs.svh"

module sllc_blank_timer #(
   parameter int unsigned CYCLES = 1
) (
   input  wire logic clk_i,      // System clock
   input  wire logic rst_n_i,    // Synchronous reset, active low
   input  wire logic restart_i,  // Start or restart the window
   output logic      busy_o      // Window running
);

   sllc_pkg::sllc_timer_t s_q;
   sllc_pkg::sllc_timer_t s_d;

   // -------------------------------------------------------------------------
   // Countdown; a restart while busy stretches the window again
   // -------------------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      if (restart_i) begin
         s_d.busy  = 1'b1;
         s_d.count = `SLLC_BLANK_CW'(CYCLES - 1);
      end else if (s_q.busy) begin
         if (s_q.count == '0) begin
            s_d.busy = 1'b0;
         end else begin
            s_d.count = s_q.count - `SLLC_BLANK_CW'(1);
         end
      end
      if (!rst_n_i) begin
         s_d = '0;
      end
   end

   // State register
   always_ff @(posedge clk_i) begin
      s_q <= s_d;
   end

   assign busy_o = s_q.busy;

endmodule // sllc_blank_timer

`default_nettype wire

// ---- verilog/sllc_intf_decode.sv ----
// Decodes the local control interface selection from field and pins.
// Assumes pin levels already synchronous; purely combinational.
`default_nettype none
`include "sllc_defs.svh"

module sllc_intf_decode (
   input  wire logic [1:0] intf_type_i,       // Local interface type field
   input  wire logic       bus_select_pin_i,  // Bus select pin level
   input  wire logic       ctrl_dir_pin_i,    // Control direction pin level
   output logic            i2c_o,             // Base mode uses I2C
   output logic            uart_o,            // Base mode uses UART
   output logic            disable_o          // Local channel off
);

   logic base_mode;

   // -------------------------------------------------------------------------
   // Field only steers the choice in base mode; upper codes always disable
   // -------------------------------------------------------------------------
   always_comb begin
      base_mode = !bus_select_pin_i && ctrl_dir_pin_i;
      disable_o = intf_type_i[1];                                           // R5
      i2c_o     = base_mode && (intf_type_i == `SLLC_INTF_I2C);              // R4
      uart_o    = base_mode && (intf_type_i == `SLLC_INTF_UART);             // R4
   end

endmodule // sllc_intf_decode

`default_nettype wire

// ---- verilog/sllc_regs.sv ----
// Serial link control register bank with an APB slave port.
// Assumes an APB master on clk_i and strap pins steady around reset.
//
// Contract
// R1: Link control bit 7 enables serial link; resets to inverse of auto-start pin.
// R2: Reverse channel unavailable for 500 us after link start or stop.
// R3: Link control bit 4 selects sleep; reset value from strap pins.
// R4: Bits 3:2 pick I2C (00) or UART (01) in base mode; reset 00.
// R5: Interface type 10 or 11 disables the local control channel.
// R6: Bit 1 enables reverse channel reception; reset 1.
// R7: Bit 0 enables forward channel sending; reset 1.
// R8: Second register bit 7 set omits register address in UART-to-I2C conversion.
// R9: Second register bits 5:4 set output level 100-400 mV; reset 11.
// R10: Config link bit 6, test pattern bit 5, jitter filter disable bit.
//
// Added by the designer: the APB slave port.
`default_nettype none
`include "sllc_defs.svh"

module sllc_regs #(
   parameter int unsigned BLANK_CYCLES = `SLLC_BLANK_TIME_US * `SLLC_CLK_MHZ
) (
   input  wire logic                    clk_i,                    // 50 MHz clock
   input  wire logic                    rst_n_i,                  // Sync reset, low
   // APB slave
   input  wire logic                    psel_i,                   // Slave select
   input  wire logic                    penable_i,                // Access phase
   input  wire logic                    pwrite_i,                 // Write access
   input  wire logic [7:0]              paddr_i,                  // Byte address
   input  wire logic [`SLLC_DATA_W-1:0] pwdata_i,                 // Write data
   input  wire logic [3:0]              pstrb_i,                  // Byte lanes
   output logic                         pready_o,                 // Transfer done
   output logic [`SLLC_DATA_W-1:0]      prdata_o,                 // Read data
   output logic                         pslverr_o,                // Unmapped address
   // Strap and mode pins
   input  wire logic                    auto_start_pin_i,         // Auto start strap
   input  wire logic                    control_direction_pin_i,  // Control dir strap
   input  wire logic                    bus_select_pin_i,         // Bus select pin
   // Control outputs
   output logic                         serial_link_enable_o,     // Link on
   output logic                         config_link_enable_o,     // Config link on
   output logic                         test_pattern_enable_o,    // Test pattern on
   output logic                         sleep_mode_o,             // Sleep requested
   output logic [1:0]                   local_interface_type_o,   // Type field
   output logic                         local_i2c_active_o,       // Local I2C used
   output logic                         local_uart_active_o,      // Local UART used
   output logic                         local_channel_disable_o,  // Local channel off
   output logic                         reverse_channel_enable_o, // Raw enable bit
   output logic                         reverse_channel_active_o, // Enabled, not blanked
   output logic                         forward_channel_enable_o, // Forward sending on
   output logic                         conversion_method_o,      // Command byte only
   output logic                         jitter_filter_disable_o,  // Filter bypassed
   output logic [1:0]                   output_level_select_o     // Output level code
);

   // -------------------------------------------------------------------------
   // Declarations
   // -------------------------------------------------------------------------
   sllc_pkg::sllc_state_t s_q;
   sllc_pkg::sllc_state_t s_d;

   logic setup_phase;
   logic access_phase;
   logic addr_hit;
   logic wr_lane_ok;
   logic link_toggle;
   logic blank_busy;
   logic dec_i2c;
   logic dec_uart;
   logic dec_disable;

   // -------------------------------------------------------------------------
   // Sub-blocks
   // -------------------------------------------------------------------------
   // Window after each link start or stop; count is long, so it is a parameter
   sllc_blank_timer #(
      .CYCLES    (BLANK_CYCLES)
   ) u_blank (
      .clk_i     (clk_i),
      .rst_n_i   (rst_n_i),
      .restart_i (link_toggle),
      .busy_o    (blank_busy)
   );

   // Local interface choice from field and pins
   sllc_intf_decode u_decode (
      .intf_type_i      (s_q.link.local_interface_type),
      .bus_select_pin_i (bus_select_pin_i),
      .ctrl_dir_pin_i   (control_direction_pin_i),
      .i2c_o            (dec_i2c),
      .uart_o           (dec_uart),
      .disable_o        (dec_disable)
   );

   // -------------------------------------------------------------------------
   // Next state
   // -------------------------------------------------------------------------
   // Zero wait state: read data and error are prepared in the setup cycle so
   // that pready, prdata and pslverr all come straight from flops.
   always_comb begin
      s_d          = s_q;
      setup_phase  = psel_i && !penable_i;
      access_phase = psel_i && penable_i && s_q.pready;
      wr_lane_ok   = pstrb_i[0];
      addr_hit     = (paddr_i == `SLLC_ADDR_LINK) ||
                     (paddr_i == `SLLC_ADDR_CONV) ||
                     (paddr_i == `SLLC_ADDR_STAT);

      // Handshake flags last exactly one access cycle
      s_d.pready  = setup_phase;
      s_d.pslverr = setup_phase && !addr_hit;

      // Read path, captured in the setup cycle
      if (setup_phase) begin
         case (paddr_i)
            `SLLC_ADDR_LINK: begin
               s_d.prdata = {24'h0, s_q.link};
            end
            `SLLC_ADDR_CONV: begin
               s_d.prdata = {24'h0, s_q.conv};
            end
            `SLLC_ADDR_STAT: begin
               s_d.prdata = {27'h0, s_q.lcc_disable, s_q.uart_active,
                             s_q.i2c_active, s_q.rc_active, blank_busy};
            end
            default: begin
               s_d.prdata = '0;
            end
         endcase
      end

      // Write path; only the low byte lane carries register data
      if (access_phase && pwrite_i && wr_lane_ok) begin
         case (paddr_i)
            `SLLC_ADDR_LINK: begin
               s_d.link = sllc_pkg::sllc_link_t'(pwdata_i[7:0]);            // R1
            end
            `SLLC_ADDR_CONV: begin
               s_d.conv.conversion_method     = pwdata_i[7];                 // R8
               s_d.conv.jitter_filter_disable = pwdata_i[6];                 // R10
               s_d.conv.output_level_select   = pwdata_i[5:4];               // R9
               s_d.conv.reserved              = `SLLC_CONV_RSVD;
            end
            default: begin
               s_d.conv = s_q.conv;
            end
         endcase
      end

      // Start and stop both open the blanking window
      link_toggle = s_d.link.serial_link_enable != s_q.link.serial_link_enable; // R2

      // Reverse reception needs the enable bit and a closed window
      s_d.rc_active   = s_q.link.reverse_channel_enable && !blank_busy;      // R2 R6
      s_d.i2c_active  = dec_i2c;                                              // R4
      s_d.uart_active = dec_uart;                                             // R4
      s_d.lcc_disable = dec_disable;                                          // R5

      // Synchronous reset; straps are sampled on every reset cycle, so the
      // value seen at the last reset edge is the one that sticks
      if (!rst_n_i) begin
         s_d                            = '0;
         s_d.link.serial_link_enable    = !auto_start_pin_i;                 // R1
         s_d.link.config_link_enable    = `SLLC_CFG_LINK_RST;                // R10
         s_d.link.test_pattern_enable   = `SLLC_TEST_PAT_RST;                // R10
         s_d.link.sleep_mode            = control_direction_pin_i &&
                                          auto_start_pin_i;                  // R3
         s_d.link.local_interface_type  = `SLLC_INTF_TYPE_RST;               // R4
         s_d.link.reverse_channel_enable = `SLLC_REV_EN_RST;                 // R6
         s_d.link.forward_channel_enable = `SLLC_FWD_EN_RST;                 // R7
         s_d.conv.conversion_method     = `SLLC_METHOD_RST;                  // R8
         s_d.conv.jitter_filter_disable = `SLLC_JIT_DIS_RST;                 // R10
         s_d.conv.output_level_select   = `SLLC_LEVEL_RST;                   // R9
         s_d.conv.reserved              = `SLLC_CONV_RSVD;
      end
   end

   // -------------------------------------------------------------------------
   // State register
   // -------------------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      s_q <= s_d;
   end

   // -------------------------------------------------------------------------
   // Outputs, all straight from state flops
   // -------------------------------------------------------------------------
   assign pready_o                 = s_q.pready;
   assign prdata_o                 = s_q.prdata;
   assign pslverr_o                = s_q.pslverr;
   assign serial_link_enable_o     = s_q.link.serial_link_enable;             // R1
   assign config_link_enable_o     = s_q.link.config_link_enable;             // R10
   assign test_pattern_enable_o    = s_q.link.test_pattern_enable;            // R10
   assign sleep_mode_o             = s_q.link.sleep_mode;                     // R3
   assign local_interface_type_o   = s_q.link.local_interface_type;
   assign local_i2c_active_o       = s_q.i2c_active;
   assign local_uart_active_o      = s_q.uart_active;
   assign local_channel_disable_o  = s_q.lcc_disable;
   assign reverse_channel_enable_o = s_q.link.reverse_channel_enable;         // R6
   assign reverse_channel_active_o = s_q.rc_active;
   assign forward_channel_enable_o = s_q.link.forward_channel_enable;         // R7
   assign conversion_method_o      = s_q.conv.conversion_method;              // R8
   assign jitter_filter_disable_o  = s_q.conv.jitter_filter_disable;          // R10
   assign output_level_select_o    = s_q.conv.output_level_select;            // R9

endmodule // sllc_regs

`default_nettype wire

// ---- verification/sllc_regs_props.sv ----
// Concurrent checks on the serial link control register bank.
// Assumes binding into sllc_regs; sees only its ports.
`default_nettype none
`include "sllc_defs.svh"

module sllc_regs_props #(
   parameter int unsigned BLANK_CYCLES = `SLLC_BLANK_TIME_US * `SLLC_CLK_MHZ
) (
   input wire logic        clk_i,                    // Clock
   input wire logic        rst_n_i,                  // Sync reset, low
   input wire logic        psel_i,                   // Select
   input wire logic        penable_i,                // Access phase
   input wire logic        pwrite_i,                 // Write
   input wire logic [7:0]  paddr_i,                  // Byte address
   input wire logic [31:0] pwdata_i,                 // Write data
   input wire logic [3:0]  pstrb_i,                  // Lanes
   input wire logic        pready_o,                 // Done
   input wire logic        pslverr_o,                // Error
   input wire logic        bus_select_pin_i,         // Bus select
   input wire logic        control_direction_pin_i,  // Direction
   input wire logic [7:0]  link_o,                   // Link bits
   input wire logic [3:0]  conv_o,                   // Conv bits
   input wire logic        local_i2c_active_o,       // I2C used
   input wire logic        local_uart_active_o,      // UART used
   input wire logic        local_channel_disable_o,  // Local off
   input wire logic        reverse_channel_active_o  // Not blanked
);
   // ------------------------------------------------------------------
   // Handshake and register effects
   // ------------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   // Lane 0 carries the whole byte, so only it qualifies a write
   logic wr_ok;
   assign wr_ok = psel_i && penable_i && pready_o && pwrite_i && pstrb_i[0];

   chk_rdy_setup: assert property (psel_i && !penable_i |=> pready_o)
      else $error("no ready after setup");
   chk_rdy_single: assert property (pready_o |=> !pready_o)
      else $error("ready longer than one cycle");
   chk_err_map: assert property (pready_o |-> pslverr_o == !(paddr_i inside
      {`SLLC_ADDR_LINK, `SLLC_ADDR_CONV, `SLLC_ADDR_STAT}))
      else $error("error flag wrong for address");
   chk_link_write: assert property (
      wr_ok && paddr_i == `SLLC_ADDR_LINK |=> link_o == $past(pwdata_i[7:0]))
      else $error("link control write lost");
   chk_conv_write: assert property (
      wr_ok && paddr_i == `SLLC_ADDR_CONV |=> conv_o == $past(pwdata_i[7:4]))
      else $error("conversion write lost");
   // ------------------------------------------------------------------
   // Blanking and decodes
   // ------------------------------------------------------------------
   chk_blank_start: assert property (
      $past(rst_n_i) && $changed(link_o[7]) |-> ##2 !reverse_channel_active_o [*8])
      else $error("reverse channel not blanked");
   chk_rev_gate: assert property (!link_o[1] |=> !reverse_channel_active_o)
      else $error("reverse channel active while disabled");
   chk_i2c_sel: assert property ($past(rst_n_i) |-> local_i2c_active_o ==
      $past(link_o[3:2] == `SLLC_INTF_I2C && !bus_select_pin_i && control_direction_pin_i))
      else $error("I2C select decode wrong");
   chk_uart_sel: assert property ($past(rst_n_i) |-> local_uart_active_o ==
      $past(link_o[3:2] == `SLLC_INTF_UART && !bus_select_pin_i && control_direction_pin_i))
      else $error("UART select decode wrong");
   chk_lcc_off: assert property (
      $past(rst_n_i) |-> local_channel_disable_o == $past(link_o[3]))
      else $error("local channel disable wrong");
endmodule // sllc_regs_props

bind sllc_regs sllc_regs_props #(.BLANK_CYCLES(BLANK_CYCLES)) u_props (
   .clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
   .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
   .pready_o(pready_o), .pslverr_o(pslverr_o), .bus_select_pin_i(bus_select_pin_i),
   .control_direction_pin_i(control_direction_pin_i),
   .link_o({serial_link_enable_o, config_link_enable_o, test_pattern_enable_o,
      sleep_mode_o, local_interface_type_o, reverse_channel_enable_o,
      forward_channel_enable_o}),
   .conv_o({conversion_method_o, jitter_filter_disable_o, output_level_select_o}),
   .local_i2c_active_o(local_i2c_active_o), .local_uart_active_o(local_uart_active_o),
   .local_channel_disable_o(local_channel_disable_o),
   .reverse_channel_active_o(reverse_channel_active_o));
`default_nettype wire

// ---- verification/test_serial_link_control_regs.sv ----
// Self-checking bench for the serial link control register bank.
// Assumes sllc_regs and its checker are compiled before it.
`default_nettype none
`include "sllc_defs.svh"

module test_serial_link_control_regs;
   timeunit 1ns;
   timeprecision 1ps;

   // ------------------------------------------------------------------
   // Signals and design
   // ------------------------------------------------------------------
   localparam int BLANK = 20;  // Short window keeps the run brief
   logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
   logic        auto = 1'b1, cdir = 1'b1, bsel = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [3:0]  pstrb = 4'h0;
   wire  [31:0] prdata;
   wire  [7:0]  ctl;
   wire  [3:0]  cv;
   wire         prdy, perr, i2c, uart, ldis, ract;
   int          error_cnt = 0, checks = 0;

   always #10 clk = ~clk;

   sllc_regs #(.BLANK_CYCLES(BLANK)) uut (
      .clk_i(clk), .rst_n_i(rst_n), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
      .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb), .pready_o(prdy),
      .prdata_o(prdata), .pslverr_o(perr), .auto_start_pin_i(auto),
      .control_direction_pin_i(cdir), .bus_select_pin_i(bsel),
      .serial_link_enable_o(ctl[7]), .config_link_enable_o(ctl[6]),
      .test_pattern_enable_o(ctl[5]), .sleep_mode_o(ctl[4]),
      .local_interface_type_o(ctl[3:2]), .reverse_channel_enable_o(ctl[1]),
      .forward_channel_enable_o(ctl[0]), .local_i2c_active_o(i2c),
      .local_uart_active_o(uart), .local_channel_disable_o(ldis),
      .reverse_channel_active_o(ract), .conversion_method_o(cv[3]),
      .jitter_filter_disable_o(cv[2]), .output_level_select_o(cv[1:0]));

   // ------------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------------
   task automatic conclude();
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string m);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask

   // One APB transfer, then an idle cycle so strobes never re-assert in one step
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s, output logic [31:0] rd, output logic er);
      int n;
      n = 0;
      psel <= 1'b1;
      pen <= 1'b0;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge clk);
      pen <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (prdy !== 1'b1 && n < 40);
      if (prdy !== 1'b1) begin
         error_cnt++;
         conclude();
      end
      rd = prdata;
      er = perr;
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge clk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, {24'h0, d}, s, r, e);
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [7:0] x, input string m);
      logic [31:0] r;
      logic        e;
      apb(1'b0, a, 32'h0, 4'h0, r, e);
      check(r, {24'h0, x}, m);
      check(e, 1'b0, m);
   endtask

   // ------------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------------
   // Reset with chosen strap levels, then look at the link, conversion and reverse active power-up values
   task automatic t_reset(input logic a, input logic d);
      auto <= a;
      cdir <= d;
      rst_n <= 1'b0;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      check({ctl, cv, ract}, {~a, 2'b00, a & d, 4'b0011, 4'b0111, 1'b1}, "reset");
      rdchk(`SLLC_ADDR_LINK, {~a, 2'b00, a & d, 4'b0011}, "link rst");
      rdchk(`SLLC_ADDR_CONV, 8'h70, "conv rst");
   endtask

   // Full writes stick; a write with lane 0 off changes nothing
   task automatic t_link();
      logic [7:0] v [4] = '{8'h5a, 8'ha5, 8'h00, 8'hff};
      foreach (v[i]) begin
         wr(`SLLC_ADDR_LINK, v[i], 4'hf);
         check(ctl, v[i], "link out");
         wr(`SLLC_ADDR_LINK, ~v[i], 4'he);
         rdchk(`SLLC_ADDR_LINK, v[i], "link read");
      end
   endtask

   // Every output level, method and jitter code; low nibble reads zero
   task automatic t_conv();
      for (int i = 0; i < 16; i++) begin
         wr(`SLLC_ADDR_CONV, {i[3:0], 4'hf}, 4'h1);
         check(cv, i[3:0], "conv out");
         rdchk(`SLLC_ADDR_CONV, {i[3:0], 4'h0}, "conv read");
      end
   endtask

   // All type codes against both pin levels
   task automatic t_decode();
      logic [1:0] t;
      for (int k = 0; k < 16; k++) begin
         t = k[3:2];
         bsel <= k[1];
         cdir <= k[0];
         wr(`SLLC_ADDR_LINK, {4'h0, t, 2'b11}, 4'hf);
         @(posedge clk);
         check({i2c, uart, ldis}, {t == 2'h0 && !k[1] && k[0],
            t == 2'h1 && !k[1] && k[0], t[1]}, "decode");
      end
   endtask

   // Flip the link enable and time the reverse channel gap
   task automatic t_blank(input logic [7:0] v);
      int n, lo;
      n = 0;
      lo = 0;
      wr(`SLLC_ADDR_LINK, v, 4'hf);
      while (ract !== 1'b0 && n < 8) begin
         @(posedge clk);
         n++;
      end
      while (ract === 1'b0 && lo < 200) begin
         @(posedge clk);
         lo++;
      end
      check(lo == BLANK || lo == BLANK + 1, 1'b1, "blank length");
   endtask

   // Unmapped access errors and writes nothing; status ignores writes
   task automatic t_bad();
      logic [31:0] r;
      logic        e;
      apb(1'b0, 8'h20, 32'h0, 4'h0, r, e);
      check({e, r[30:0]}, 32'h8000_0000, "unmapped read");
      apb(1'b1, 8'h20, 32'hff, 4'hf, r, e);
      check(e, 1'b1, "unmapped write");
      apb(1'b1, `SLLC_ADDR_STAT, 32'hff, 4'hf, r, e);
      check(e, 1'b0, "status write");
      rdchk(`SLLC_ADDR_LINK, 8'h03, "link kept");
      // Window long closed, pins off base mode: only reverse active is set
      rdchk(`SLLC_ADDR_STAT, 8'h02, "status");
   endtask

   initial begin
      t_reset(1'b1, 1'b1);
      t_reset(1'b0, 1'b1);
      t_link();
      t_conv();
      t_decode();
      t_blank(8'h83);
      t_blank(8'h03);
      t_bad();
      t_reset(1'b1, 1'b0);
      conclude();
   end
endmodule // test_serial_link_control_regs
`default_nettype wire
